// >>> include/fscc_pkg.sv
// Purpose: Shared constants and types for the flash status and configuration command logic.
// Assumes: A 100 MHz system clock that oversamples the serial link.
// Notes:   Reset images of the status bytes are plain defaults.
package fscc_pkg;
  localparam logic [7:0] OP_RD_SR1  = 8'h05;
  localparam logic [7:0] OP_RD_SR2  = 8'h35;
  localparam logic [7:0] OP_RD_SR3  = 8'h33;
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_ARM_VOL = 8'h50;
  localparam logic [7:0] OP_WR_SR   = 8'h01;
  localparam int SR1_BUSY = 0;
  localparam int SR1_WEL  = 1;
  localparam int SR2_PROTECT_LEVEL_ONE = 0;
  localparam int SR2_QE   = 1;
  localparam int SR2_CMP  = 6;
  localparam logic [7:0] SR1_WR_MASK = 8'hFC;
  localparam logic [7:0] SR2_WR_MASK = 8'h7F;
  localparam logic [7:0] SR3_WR_MASK = 8'h7F;
  localparam logic [7:0] SR2_LB_MASK = 8'h3C;
  localparam logic [7:0] NV_SR1_RST  = 8'h00;
  localparam logic [7:0] NV_SR2_RST  = 8'h00;
  localparam logic [7:0] SR3_RST     = 8'h00;
  localparam int CLK_PERIOD_NS           = 10;
  localparam int STATUS_WRITE_TIME_US    = 10000;
  localparam int VOLATILE_UPDATE_TIME_NS = 50;
  localparam int STATUS_WRITE_CYC = STATUS_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int VOL_UPD_CYC_RAW  = VOLATILE_UPDATE_TIME_NS / CLK_PERIOD_NS;
  localparam int VOL_UPD_CYC      = (VOL_UPD_CYC_RAW < 1) ? 1 : VOL_UPD_CYC_RAW;
  localparam int TMR_W = 24;

  typedef enum logic [1:0] {
    FSCC_M_CMD   = 2'b00,
    FSCC_M_READ  = 2'b01,
    FSCC_M_WSR   = 2'b10,
    FSCC_M_OTHER = 2'b11
  } fscc_mode_t;

  typedef enum logic [1:0] {
    FSCC_E_IDLE = 2'b00,
    FSCC_E_NV   = 2'b01,
    FSCC_E_VOL  = 2'b10
  } fscc_eng_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } fscc_spi_in_t;

  typedef struct packed {
    logic so;
    logic so_oe;
  } fscc_spi_out_t;

  typedef struct packed {
    logic [7:0] r1;
    logic [7:0] r2;
    logic [7:0] r3;
  } fscc_sr_t;
endpackage

// >>> logic/fscc_core.sv
// Purpose: Serial flash command logic for reading and writing the status registers.
// Assumes: Link pins are asynchronous and oversampled; op_busy and op_done come from
//          array logic on clk_sys.
// Notes:   Program, erase and read-array commands live elsewhere.
//
// Overview of operation
// - Opcodes 05h, 35h, 33h select status register one, two or three for reading.
// - Selected status byte leaves on falling clock edges, most significant bit first.
// - Register one read is accepted even while an operation is busy.
// - Each further byte carries a fresh value of the selected register.
// - Bit 0 of register one shows busy.
// - Status output repeats until chip select goes high.
// - A complete 06h command sets the write enable latch unless busy.
// - Writes that change storage need the latch set first.
// - At reset the non-volatile image is copied into the working registers.
// - 50h leaves the latch alone and arms only the next status write.
// - A complete 04h command clears the write enable latch unless busy.
// - Latch clears after power-up, on op_done unless a 06h command completes in that cycle, and when a non-volatile status write completes.
// - Only register one bits 7:2, two and three bits 6:0 are writable.
// - Lock bits once set never return to zero.
// - A non-volatile status write needs the latch, then 01h and data.
// - Volatile write leaves the latch unchanged and leaves protect level one and locks.
// - Deselect off a byte boundary discards the status write.
// - One data byte clears complement and quad bits unless protect level one.
// - One or two data bytes leave register three unchanged.
// - Non-volatile write runs timed with busy set, then clears busy and latch.
// - Volatile write updates within a short time and busy stays zero.
// - All bytes travel most significant bit first.
`timescale 1ns/1ps
module fscc_core #(
  parameter int STATUS_WRITE_CYCLES = fscc_pkg::STATUS_WRITE_CYC
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire fscc_pkg::fscc_spi_in_t  spi_i,
  output fscc_pkg::fscc_spi_out_t      spi_o,
  input  wire logic                    op_busy,
  input  wire logic                    op_done,
  output logic [7:0]                   status_reg_one,
  output logic [7:0]                   status_reg_two,
  output logic [7:0]                   status_reg_three
);
  import fscc_pkg::*;

  typedef struct packed {
    logic [2:0]      cs_sy;
    logic [2:0]      sck_sy;
    logic [2:0]      si_sy;
    logic            cs_f;
    logic            sck_f;
    logic            si_f;
    fscc_mode_t      mode;
    logic [2:0]      bits;
    logic [2:0]      nbytes;
    logic [7:0]      sh;
    logic [7:0]      op;
    logic [7:0]      d0;
    logic [7:0]      d1;
    logic [7:0]      d2;
    logic [7:0]      tx;
    logic [2:0]      obit;
    logic            so;
    logic            so_oe;
    logic            arm;
    logic            loaded;
    logic [7:0]      nv1;
    logic [7:0]      nv2;
    fscc_sr_t        sr;
    fscc_sr_t        pend;
    fscc_eng_t       eng;
    logic [TMR_W-1:0] tmr;
  } fscc_state_t;

  fscc_state_t s;
  fscc_state_t n;
  logic [1:0]  cs_e;
  logic [1:0]  sck_e;
  logic [7:0]  rd_val;
  logic        busy;
  logic        ends_ok;
  logic        wsr_go;

  // Returns {rise, fall} once the second and third stages agree on a new level.
  function automatic logic [1:0] flt_edge(input logic f, input logic [2:0] sy);
    logic ok;
    ok = (sy[1] == sy[2]) && (sy[1] != f);
    flt_edge = {ok & sy[1], ok & ~sy[1]};
  endfunction

  function automatic logic [7:0] pick_reg(input logic [7:0] op, input fscc_sr_t sr);
    case (op)
      OP_RD_SR2: pick_reg = sr.r2;
      OP_RD_SR3: pick_reg = sr.r3;
      default:   pick_reg = sr.r1;
    endcase
  endfunction

  function automatic fscc_sr_t merge(input fscc_sr_t old, input logic [7:0] a,
                                     input logic [7:0] b, input logic [7:0] c,
                                     input logic [2:0] nb, input logic vol);
    fscc_sr_t r;
    r = old;
    r.r1 = (old.r1 & ~SR1_WR_MASK) | (a & SR1_WR_MASK);
    if (nb == 3'd2) begin
      if (!old.r2[SR2_PROTECT_LEVEL_ONE]) begin
        r.r2[SR2_CMP] = 1'b0;
        r.r2[SR2_QE]  = 1'b0;
      end
    end else begin
      r.r2 = (old.r2 & ~SR2_WR_MASK) | (b & SR2_WR_MASK);
      r.r2 = (r.r2 & ~SR2_LB_MASK) | ((old.r2 | b) & SR2_LB_MASK);
      if (vol) begin
        r.r2[SR2_PROTECT_LEVEL_ONE] = old.r2[SR2_PROTECT_LEVEL_ONE];
        r.r2 = (r.r2 & ~SR2_LB_MASK) | (old.r2 & SR2_LB_MASK);
      end
    end
    if (nb == 3'd4) begin
      r.r3 = (old.r3 & ~SR3_WR_MASK) | (c & SR3_WR_MASK);
    end
    merge = r;
  endfunction

  assign cs_e    = flt_edge(s.cs_f, s.cs_sy);
  assign sck_e   = flt_edge(s.sck_f, s.sck_sy);
  assign busy    = s.sr.r1[SR1_BUSY];
  assign rd_val  = pick_reg(s.op, s.sr);
  // A command only counts when chip select rises on a whole byte.
  assign ends_ok = cs_e[1] && (s.bits == 3'd0) && (s.nbytes != 3'd0);
  assign wsr_go  = ends_ok && (s.op == OP_WR_SR) && (s.nbytes >= 3'd2) && !busy
                   && (s.eng == FSCC_E_IDLE) && (s.arm || s.sr.r1[SR1_WEL]);

  always_comb begin
    n = s;
    n.cs_sy  = {s.cs_sy[1:0], spi_i.cs_n};
    n.sck_sy = {s.sck_sy[1:0], spi_i.sck};
    n.si_sy  = {s.si_sy[1:0], spi_i.si};
    if (s.cs_sy[1] == s.cs_sy[2]) n.cs_f = s.cs_sy[1];
    if (s.sck_sy[1] == s.sck_sy[2]) n.sck_f = s.sck_sy[1];
    if (s.si_sy[1] == s.si_sy[2]) n.si_f = s.si_sy[1];

    if (cs_e[0]) begin
      n.mode   = FSCC_M_CMD;
      n.bits   = 3'd0;
      n.nbytes = 3'd0;
      n.obit   = 3'd0;
    end else if (!s.cs_f && sck_e[1]) begin
      n.sh   = {s.sh[6:0], s.si_f};
      n.bits = s.bits + 3'd1;
      if (s.bits == 3'd7) begin
        if (s.nbytes != 3'd4) n.nbytes = s.nbytes + 3'd1;
        case (s.mode)
          FSCC_M_CMD: begin
            n.op = n.sh;
            if (n.sh == OP_RD_SR1 || (!busy && (n.sh == OP_RD_SR2 || n.sh == OP_RD_SR3))) begin
              n.mode = FSCC_M_READ;
            end else if (n.sh == OP_WR_SR) begin
              n.mode = FSCC_M_WSR;
            end else begin
              n.mode = FSCC_M_OTHER;
            end
          end
          FSCC_M_WSR: begin
            case (s.nbytes)
              3'd1:    n.d0 = n.sh;
              3'd2:    n.d1 = n.sh;
              3'd3:    n.d2 = n.sh;
              default: n.d2 = s.d2;
            endcase
          end
          default: n.op = s.op;
        endcase
      end
    end else if (!s.cs_f && sck_e[0] && s.mode == FSCC_M_READ) begin
      // Reloading at every byte start keeps repeated bytes current.
      n.so_oe = 1'b1;
      n.obit  = s.obit + 3'd1;
      if (s.obit == 3'd0) begin
        n.so = rd_val[7];
        n.tx = {rd_val[6:0], 1'b0};
      end else begin
        n.so = s.tx[7];
        n.tx = {s.tx[6:0], 1'b0};
      end
    end

    if (cs_e[1]) begin
      n.so_oe = 1'b0;
      n.mode  = FSCC_M_CMD;
      if (s.nbytes != 3'd0) n.arm = 1'b0;
    end
    if (ends_ok && s.nbytes == 3'd1 && !busy) begin
      case (s.op)
        OP_SET_WEL: n.sr.r1[SR1_WEL] = 1'b1;
        OP_CLR_WEL: n.sr.r1[SR1_WEL] = 1'b0;
        OP_ARM_VOL: n.arm = 1'b1;
        default:    n.arm = 1'b0;
      endcase
    end
    if (op_done && !(ends_ok && s.op == OP_SET_WEL)) n.sr.r1[SR1_WEL] = 1'b0;

    if (wsr_go) begin
      n.pend = merge(s.sr, s.d0, s.d1, s.d2, s.nbytes, s.arm);
      if (s.arm) begin
        n.eng = FSCC_E_VOL;
        n.tmr = TMR_W'(VOL_UPD_CYC);
      end else begin
        n.eng = FSCC_E_NV;
        n.tmr = TMR_W'(STATUS_WRITE_CYCLES);
      end
    end else if (s.eng != FSCC_E_IDLE) begin
      n.tmr = s.tmr - TMR_W'(1);
      if (s.tmr == TMR_W'(1)) begin
        n.eng = FSCC_E_IDLE;
        n.sr.r1[7:2] = s.pend.r1[7:2];
        n.sr.r2 = s.pend.r2;
        n.sr.r3 = s.pend.r3;
        if (s.eng == FSCC_E_NV) begin
          n.nv1 = {s.pend.r1[7:2], 2'b00};
          n.nv2 = s.pend.r2;
          n.sr.r1[SR1_WEL] = 1'b0;
        end
      end
    end

    if (!s.loaded) begin
      // The image only exists after reset release, so the copy is a clocked step.
      n.loaded = 1'b1;
      n.sr.r1  = s.nv1 & SR1_WR_MASK;
      n.sr.r2  = s.nv2;
    end
    n.sr.r2[7] = 1'b0;
    n.sr.r3[7] = 1'b0;
    n.sr.r1[SR1_BUSY] = (n.eng == FSCC_E_NV) | op_busy;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s        <= '0;
      s.cs_sy  <= 3'h7;
      s.cs_f   <= 1'b1;
      s.mode   <= FSCC_M_CMD;
      s.eng    <= FSCC_E_IDLE;
      s.nv1    <= NV_SR1_RST;
      s.nv2    <= NV_SR2_RST;
      s.sr.r3  <= SR3_RST;
    end else begin
      s <= n;
    end
  end

  assign spi_o.so         = s.so;
  assign spi_o.so_oe      = s.so_oe;
  assign status_reg_one   = s.sr.r1;
  assign status_reg_two   = s.sr.r2;
  assign status_reg_three = s.sr.r3;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Busy drops on the same edge that ends the timed write, so the last timer cycle is excluded.
  nv_busy_held_a: assert property (
    (s.eng == FSCC_E_NV && s.tmr != TMR_W'(1)) |=> status_reg_one[SR1_BUSY])
    else $error("Busy low during non-volatile status write.");
  vol_no_busy_a: assert property (
    (s.eng == FSCC_E_VOL) |=> status_reg_one[SR1_BUSY] == op_busy)
    else $error("Busy high during volatile update.");
  vol_update_time_a: assert property (
    $rose(s.eng == FSCC_E_VOL) |-> ##[1:5] s.eng == FSCC_E_IDLE)
    else $error("Volatile update too slow.");
  wel_set_a: assert property (
    (ends_ok && s.nbytes == 3'd1 && s.op == OP_SET_WEL && !busy) |=> status_reg_one[SR1_WEL])
    else $error("Latch not set by set command.");
  wel_clear_a: assert property (
    (ends_ok && s.nbytes == 3'd1 && s.op == OP_CLR_WEL && !busy) |=> !status_reg_one[SR1_WEL])
    else $error("Latch not cleared by clear command.");
  arm_keeps_wel_a: assert property (
    (ends_ok && s.op == OP_ARM_VOL && !op_done) |=> $stable(status_reg_one[SR1_WEL]))
    else $error("Arm command changed the latch.");
  nv_end_wel_a: assert property (
    (s.eng == FSCC_E_NV && s.tmr == TMR_W'(1)) |=> !status_reg_one[SR1_WEL] && s.eng == FSCC_E_IDLE)
    else $error("Latch not cleared after status write.");
  lock_sticky_a: assert property (
    s.loaded |=> ($past(status_reg_two) & ~status_reg_two & SR2_LB_MASK) == 8'h00)
    else $error("Lock bit returned to zero.");
  ro_bits_a: assert property (
    status_reg_two[7] == 1'b0 && status_reg_three[7] == 1'b0)
    else $error("Read-only status bit set.");
  so_first_bit_a: assert property (
    (!s.cs_f && sck_e[0] && s.mode == FSCC_M_READ && s.obit == 3'd0)
    |=> spi_o.so == $past(rd_val[7]) && spi_o.so_oe)
    else $error("Status byte did not start with its top bit.");
  sr3_kept_a: assert property (
    (wsr_go && s.nbytes != 3'd4) |=> s.pend.r3 == $past(status_reg_three))
    else $error("Short write touched register three.");
  oe_release_a: assert property (
    cs_e[1] |=> !spi_o.so_oe)
    else $error("Serial output still driven after deselect.");
  cut_frame_a: assert property (
    (cs_e[1] && s.bits != 3'd0 && s.eng == FSCC_E_IDLE) |=> s.eng == FSCC_E_IDLE)
    else $error("Status write started off a byte boundary.");
  arm_drop_a: assert property (
    (ends_ok && s.op != OP_ARM_VOL) |=> !s.arm)
    else $error("Volatile arm survived another command.");
endmodule // fscc_core

// >>> sim/fscc_host_model.sv
// Purpose: Host serial controller model that frames commands for the status logic.
// Assumes: Mode 0; pins move on falling clk_sys edges, twelve cycles per link bit.
// Notes:   The link clock stands still between frames; si is toggled once released.
`timescale 1ns/1ps
module fscc_host_model
  import fscc_pkg::*;
(
  input  wire logic                    clk_sys,
  output fscc_pkg::fscc_spi_in_t       spi_i,
  input  wire fscc_pkg::fscc_spi_out_t spi_o
);
  initial spi_i = 3'b100;

  task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    @(negedge clk_sys) spi_i.cs_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    for (int i = n - 1; i >= 0; i--) begin
      spi_i.si = tx[i];
      repeat (6) @(negedge clk_sys);
      spi_i.sck = 1'b1;
      rx = {rx[30:0], spi_o.so};
      repeat (6) @(negedge clk_sys);
      spi_i.sck = 1'b0;
    end
    // Deselect half a link period after the last fall, so that fall still shifts a bit out.
    repeat (6) @(negedge clk_sys);
    spi_i.cs_n = 1'b1;
    spi_i.si = ~spi_i.si;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule // fscc_host_model

// >>> sim/test_fscc_core.sv
// Purpose: Self-checking bench for the status and configuration command logic.
// Assumes: A short status write time so the timed write fits in a polling read.
// Notes:   Expected values follow from the writable masks and the lock stickiness.
`timescale 1ns/1ps
module test_fscc_core;
  import fscc_pkg::*;
  localparam int SWC = 200;
  logic          clk_sys, rst_n, op_busy, op_done;
  fscc_spi_in_t  spi_i;
  fscc_spi_out_t spi_o;
  logic [7:0]    sr1, sr2, sr3;
  logic [31:0]   rx;
  int            err_total, samples_checked, cyc;
  logic          oe_at_rise;
  logic [7:0]    ops [3] = '{OP_RD_SR1, OP_RD_SR2, OP_RD_SR3};

  fscc_core #(.STATUS_WRITE_CYCLES(SWC)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .spi_i(spi_i), .spi_o(spi_o), .op_busy(op_busy), .op_done(op_done),
    .status_reg_one(sr1), .status_reg_two(sr2), .status_reg_three(sr3));
  fscc_host_model host (.clk_sys(clk_sys), .spi_i(spi_i), .spi_o(spi_o));

  // The enable seen at the host's sampling edge shows whether the status byte was driven.
  always @(posedge spi_i.sck) oe_at_rise = spi_o.so_oe;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    host.frame({24'h0, op}, 8, rx);
  endtask

  task automatic rd(input logic [7:0] op);
    host.frame({op, 24'h0}, 32, rx);
  endtask

  // Timed writes wait out the whole self-timed window before looking.
  task automatic settle;
    repeat (SWC + 20) @(negedge clk_sys);
  endtask

  // A hang is cut short well past the some five hundred link bits of the run.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      stop_test;
    end
  end

  initial begin
    rst_n = 1'b0;
    op_busy = 1'b0;
    op_done = 1'b0;
    cyc = 0;
    err_total = 0;
    samples_checked = 0;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    foreach (ops[i]) begin
      rd(ops[i]);
      chk(rx[7:0], 8'h00);
    end
    $display("reset image test done");
    cmd(OP_SET_WEL);
    chk(sr1, 8'h02);
    rd(OP_RD_SR1);
    chk(rx[7:0], 8'h02);
    chk({7'h00, oe_at_rise}, 8'h01);
    chk({7'h00, spi_o.so_oe}, 8'h00);
    cmd(OP_CLR_WEL);
    chk(sr1, 8'h00);
    $display("latch test done");
    cmd(OP_SET_WEL);
    host.frame(32'h01FF7F7F, 32, rx);
    chk(sr1, 8'h03);
    rd(OP_RD_SR1);
    chk(rx[23:16], 8'h03);
    chk(rx[7:0], 8'hFC);
    rd(OP_RD_SR2);
    chk(rx[7:0], 8'h7F);
    rd(OP_RD_SR3);
    chk(rx[7:0], 8'h7F);
    $display("timed write test done");
    cmd(OP_SET_WEL);
    host.frame(32'h00010000, 24, rx);
    settle;
    chk(sr1, 8'h00);
    chk(sr2, 8'h3C);
    chk(sr3, 8'h7F);
    $display("lock test done");
    cmd(OP_ARM_VOL);
    chk(sr1, 8'h00);
    host.frame(32'h00011C41, 24, rx);
    repeat (4) @(negedge clk_sys);
    chk(sr1, 8'h1C);
    chk(sr2, 8'h7C);
    cmd(OP_SET_WEL);
    host.frame(32'h00000100, 16, rx);
    settle;
    chk(sr2, 8'h3C);
    chk(sr3, 8'h7F);
    cmd(OP_SET_WEL);
    host.frame(32'h00010041, 24, rx);
    settle;
    cmd(OP_SET_WEL);
    host.frame(32'h00000100, 16, rx);
    settle;
    chk(sr2, 8'h7D);
    $display("short write test done");
    cmd(OP_SET_WEL);
    host.frame(32'h00001FFF, 20, rx);
    repeat (6) @(negedge clk_sys);
    chk(sr1, 8'h02);
    cmd(OP_CLR_WEL);
    cmd(OP_ARM_VOL);
    cmd(OP_CLR_WEL);
    host.frame(32'h000001FC, 16, rx);
    repeat (10) @(negedge clk_sys);
    chk(sr1, 8'h00);
    $display("refused write test done");
    op_busy = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd(OP_RD_SR1);
    chk(rx[7:0], 8'h01);
    cmd(OP_SET_WEL);
    chk(sr1, 8'h01);
    op_busy = 1'b0;
    cmd(OP_SET_WEL);
    chk(sr1, 8'h02);
    op_done = 1'b1;
    @(negedge clk_sys) op_done = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(sr1, 8'h00);
    $display("busy test done");
    stop_test;
  end
endmodule // test_fscc_core
